// ==== design/cfh_consts.vh ====
`ifndef CFH_CONSTS_VH
`define CFH_CONSTS_VH
`define CFH_ADDR_GCTL 4'h0
`define CFH_ADDR_S1CTL 4'h1
`define CFH_ADDR_S2CTL 4'h2
`define CFH_ADDR_S1FSR 4'h3
`define CFH_ADDR_S2FSR 4'h4
`define CFH_ADDR_S1RES 4'h5
`define CFH_ADDR_S2RES 4'h6
`define CFH_ADDR_S1ATTR 4'h7
`define CFH_ADDR_S2ATTR 4'h8
`define CFH_ADDR_STAT 4'h9
`define CFH_ADDR_S1SYN 4'ha
`define CFH_ADDR_S2SYN 4'hb
`define CFH_GCTL_NSSTALLD 0
`define CFH_GCTL_SSTALLD 1
`define CFH_GCTL_NSCOVERS 2
`define CFH_GCTL_SECURE 3
`define CFH_CTL_FRS 0
`define CFH_CTL_HUF 1
`define CFH_CTL_FARE 2
`define CFH_FSR_FAULT 0
`define CFH_FSR_SS 1
`define CFH_FSR_MULTI 2
`define CFH_RES_TNR 0
`define CFH_HAS_STALL 1'b1
`define CFH_HAS_HUF 1'b1
`define CFH_RESET_CTL 3'h0
`define CFH_RESET_GCTL 4'h0
`endif

// ==== design/cfh_context_fault_handler.v ====
// Operation
// - Terminated access: no downstream, read zero
// - Abort to client only if report enabled
// - Stall held until resume write decides or fault status clears
// - Resume clears stalled-status flag
// - Per-stage select chooses stall or terminate
// - No stall support: select reads zero
// - Hit-under-fault off: block bank while faulting
// - No hit-under-fault: act as zero, writable
// - Global stall disable forces select zero
// - Secure disable overrides; nonsecure only when not secure or covered
// - Resume-terminate: no data, no new record
// - Attribute write while stalled retries
// - Hit-under-fault terminate: later fault sets multi
// - Hit-under-fault stall: later fault waits unrecorded
// - No hit-under-fault terminate: silent terminations
// - No hit-under-fault stall: later ones stall
// - Faulting stage 2 blocks only traffic that also uses stage 2
// - Check banks, translate, then re-examine status
// - Order kept; one request at a time
// - Translation starts only after checks pass
// - Fault on nonzero status with stalled flag clear sets multi only
// - Fault on clear status records full details
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cfh_consts.vh"
module cfh_context_fault_handler (
    input wire clk_sys,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire wb_err_o,
    input wire reqValid,
    output wire reqReady,
    input wire reqWrite,
    input wire reqUseS1,
    input wire reqUseS2,
    input wire [31:0] reqAddr,
    input wire [31:0] reqWdata,
    output reg rspValid,
    output reg rspAbort,
    output reg [31:0] rspRdata,
    output reg xlatStart,
    output reg [31:0] xlatAddr,
    input wire xlatDone,
    input wire xlatFault,
    input wire xlatFaultS2,
    input wire [31:0] xlatSyndrome,
    output reg dsValid,
    output reg dsWrite,
    output reg [31:0] dsAddr,
    output reg [31:0] dsWdata,
    input wire dsDone,
    input wire [31:0] dsRdata
);
    localparam ST_IDLE = 3'h0;
    localparam ST_CHECK = 3'h1;
    localparam ST_XLAT = 3'h2;
    localparam ST_DS = 3'h3;
    localparam ST_STALL = 3'h4;
    localparam ST_RESP = 3'h5;

    reg [3:0] gctl;
    reg [2:0] ctl1;
    reg [2:0] ctl2;
    reg [2:0] fsr1;
    reg [2:0] fsr2;
    reg [31:0] far1;
    reg [31:0] far2;
    reg [31:0] syn1;
    reg [31:0] syn2;
    reg [2:0] state;
    reg rWrite;
    reg rS1;
    reg rS2;
    reg stallBank2;
    reg abortOut;
    reg [31:0] rAddr;
    reg [31:0] rWdata;
    reg resume1;
    reg resume2;
    // Shared terminate bit; only one bank waits at a time
    reg resumeTnr;

    // Nonsecure disable reaches secure banks only when covered
    wire stallDis = gctl[`CFH_GCTL_SSTALLD] |
        (gctl[`CFH_GCTL_NSSTALLD] &
        (~gctl[`CFH_GCTL_SECURE] | gctl[`CFH_GCTL_NSCOVERS]));
    // Effective select: zero when stall unbuilt or disabled
    wire stall1 = ctl1[`CFH_CTL_FRS] & `CFH_HAS_STALL & ~stallDis;
    wire stall2 = ctl2[`CFH_CTL_FRS] & `CFH_HAS_STALL & ~stallDis;
    // Effective hit-under-fault: forced off when unbuilt
    wire huf1 = ctl1[`CFH_CTL_HUF] & `CFH_HAS_HUF;
    wire huf2 = ctl2[`CFH_CTL_HUF] & `CFH_HAS_HUF;
    wire flt1 = |fsr1;
    wire flt2 = |fsr2;

    // Ack blocks a second take of the same request
    wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [3:0] idx = wb_adr_i[5:2];
    // Unmapped indices read zero and ignore writes
    wire mapped = idx <= `CFH_ADDR_S2SYN;
    // Only lane 0 gates writes; upper lanes hold no fields
    wire wbWr = wbReq & wb_we_i & mapped & wb_sel_i[0];
    wire [3:0] wIdx = idx;
    // No access ever errors; bad indices are simply ignored
    assign wb_err_o = 1'b0;
    // Single outstanding request: ready only when idle
    assign reqReady = (state == ST_IDLE);

    // Pre-translation check for one bank; 0 pass, 1 silent abort, 2 wait
    function [1:0] chk;
        input f, ss, st, hu;
        begin
            chk = 2'd0;
            if (f) begin
                if (!st && ss && !hu) begin
                    chk = 2'd2;
                end else if (!st && !hu) begin
                    chk = 2'd1;
                end else if (st && !hu) begin
                    chk = 2'd2;
                end
            end
        end
    endfunction

    // Stage 2 bank is checked only when the request uses stage 2
    wire [1:0] c1 = rS1 ? chk(flt1, fsr1[`CFH_FSR_SS], stall1, huf1) : 2'd0;
    wire [1:0] c2 = rS2 ? chk(flt2, fsr2[`CFH_FSR_SS], stall2, huf2) :
        2'd0;

    always @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            gctl <= `CFH_RESET_GCTL;
            ctl1 <= `CFH_RESET_CTL;
            ctl2 <= `CFH_RESET_CTL;
            resume1 <= 1'b0;
            resume2 <= 1'b0;
            resumeTnr <= 1'b0;
        end else begin
            wb_ack_o <= wbReq;
            resume1 <= 1'b0;
            resume2 <= 1'b0;
            if (wbReq && !wb_we_i) begin
                case (idx)
                    `CFH_ADDR_GCTL: wb_dat_o <= {28'h0, gctl};
                    `CFH_ADDR_S1CTL: wb_dat_o <= {29'h0, ctl1[2],
                        huf1 | ctl1[1], stall1};
                    `CFH_ADDR_S2CTL: wb_dat_o <= {29'h0, ctl2[2],
                        huf2 | ctl2[1], stall2};
                    `CFH_ADDR_S1FSR: wb_dat_o <= {29'h0, fsr1};
                    `CFH_ADDR_S2FSR: wb_dat_o <= {29'h0, fsr2};
                    `CFH_ADDR_S1ATTR: wb_dat_o <= far1;
                    `CFH_ADDR_S2ATTR: wb_dat_o <= far2;
                    `CFH_ADDR_STAT: wb_dat_o <= {29'h0, state};
                    `CFH_ADDR_S1SYN: wb_dat_o <= syn1;
                    `CFH_ADDR_S2SYN: wb_dat_o <= syn2;
                    default: wb_dat_o <= 32'h0;
                endcase
            end
            if (wbWr) begin
                case (wIdx)
                    `CFH_ADDR_GCTL: gctl <= wb_dat_i[3:0];
                    // Select stays writable only while stall is possible
                    `CFH_ADDR_S1CTL: begin
                        ctl1[2:1] <= wb_dat_i[2:1];
                        if (`CFH_HAS_STALL && !stallDis) begin
                            ctl1[0] <= wb_dat_i[0];
                        end
                    end
                    `CFH_ADDR_S2CTL: begin
                        ctl2[2:1] <= wb_dat_i[2:1];
                        if (`CFH_HAS_STALL && !stallDis) begin
                            ctl2[0] <= wb_dat_i[0];
                        end
                    end
                    `CFH_ADDR_S1RES: begin
                        resume1 <= 1'b1;
                        resumeTnr <= wb_dat_i[`CFH_RES_TNR];
                    end
                    `CFH_ADDR_S2RES: begin
                        resume2 <= 1'b1;
                        resumeTnr <= wb_dat_i[`CFH_RES_TNR];
                    end
                    // Attribute write acts as a retry resume
                    `CFH_ADDR_S1ATTR: begin
                        resume1 <= fsr1[`CFH_FSR_SS];
                        resumeTnr <= 1'b0;
                    end
                    `CFH_ADDR_S2ATTR: begin
                        resume2 <= fsr2[`CFH_FSR_SS];
                        resumeTnr <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Fault status: hardware sets win over software clears
    wire clr1 = wbWr && wIdx == `CFH_ADDR_S1FSR;
    wire clr2 = wbWr && wIdx == `CFH_ADDR_S2FSR;
    wire newFault = state == ST_XLAT && xlatDone && xlatFault;
    wire fb2 = xlatFaultS2 & rS2;
    wire fbFlt = fb2 ? flt2 : flt1;
    wire fbSs = fb2 ? fsr2[`CFH_FSR_SS] : fsr1[`CFH_FSR_SS];
    wire fbStall = fb2 ? stall2 : stall1;
    wire fbHuf = fb2 ? huf2 : huf1;
    wire fbAbt = fb2 ? ctl2[`CFH_CTL_FARE] : ctl1[`CFH_CTL_FARE];
    wire rec = newFault && !fbFlt;
    wire multi = newFault && fbFlt && !fbSs && fbHuf;
    wire [2:0] recVal = {1'b0, fbStall, 1'b1};

    always @(posedge clk_sys) begin
        if (reset) begin
            fsr1 <= 3'h0;
            fsr2 <= 3'h0;
            far1 <= 32'h0;
            far2 <= 32'h0;
            syn1 <= 32'h0;
            syn2 <= 32'h0;
        end else begin
            if (clr1) begin
                fsr1 <= fsr1 & ~wb_dat_i[2:0];
            end
            if (clr2) begin
                fsr2 <= fsr2 & ~wb_dat_i[2:0];
            end
            if (resume1) begin
                fsr1[`CFH_FSR_SS] <= 1'b0;
            end
            if (resume2) begin
                fsr2[`CFH_FSR_SS] <= 1'b0;
            end
            // Hardware record overrides a same-cycle clear
            if (rec && !fb2) begin
                fsr1 <= recVal;
                far1 <= rAddr;
                syn1 <= xlatSyndrome;
            end
            if (rec && fb2) begin
                fsr2 <= recVal;
                far2 <= rAddr;
                syn2 <= xlatSyndrome;
            end
            if (multi && !fb2) begin
                fsr1[`CFH_FSR_MULTI] <= 1'b1;
            end
            if (multi && fb2) begin
                fsr2[`CFH_FSR_MULTI] <= 1'b1;
            end
        end
    end

    // One request in flight keeps client order intact
    always @(posedge clk_sys) begin
        if (reset) begin
            state <= ST_IDLE;
            rWrite <= 1'b0;
            rS1 <= 1'b0;
            rS2 <= 1'b0;
            rAddr <= 32'h0;
            rWdata <= 32'h0;
            stallBank2 <= 1'b0;
            abortOut <= 1'b0;
            rspValid <= 1'b0;
            rspAbort <= 1'b0;
            rspRdata <= 32'h0;
            xlatStart <= 1'b0;
            xlatAddr <= 32'h0;
            dsValid <= 1'b0;
            dsWrite <= 1'b0;
            dsAddr <= 32'h0;
            dsWdata <= 32'h0;
        end else begin
            rspValid <= 1'b0;
            xlatStart <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (reqValid) begin
                        rWrite <= reqWrite;
                        rS1 <= reqUseS1;
                        rS2 <= reqUseS2;
                        rAddr <= reqAddr;
                        rWdata <= reqWdata;
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (c1 == 2'd2 || c2 == 2'd2) begin
                        stallBank2 <= (c2 == 2'd2);
                        state <= ST_STALL;
                    end else if (c1 == 2'd1 || c2 == 2'd1) begin
                        abortOut <= (c1 == 2'd1) ? ctl1[`CFH_CTL_FARE] :
                            ctl2[`CFH_CTL_FARE];
                        rspRdata <= 32'h0;
                        state <= ST_RESP;
                    end else begin
                        // Translation waits for the check
                        xlatStart <= 1'b1;
                        xlatAddr <= rAddr;
                        state <= ST_XLAT;
                    end
                end
                ST_XLAT: begin
                    if (xlatDone && !xlatFault) begin
                        dsValid <= 1'b1;
                        dsWrite <= rWrite;
                        dsAddr <= rAddr;
                        dsWdata <= rWdata;
                        state <= ST_DS;
                    end else if (xlatDone) begin
                        // Unrecorded stall waits on the original fault
                        if ((fbFlt && fbSs) || (!fbFlt && fbStall)) begin
                            stallBank2 <= fb2;
                            state <= ST_STALL;
                        end else begin
                            abortOut <= fbAbt;
                            rspRdata <= 32'h0;
                            state <= ST_RESP;
                        end
                    end
                end
                ST_DS: begin
                    // Downstream request held until its done pulse
                    if (dsDone) begin
                        dsValid <= 1'b0;
                        rspRdata <= rWrite ? 32'h0 : dsRdata;
                        abortOut <= 1'b0;
                        state <= ST_RESP;
                    end
                end
                ST_STALL: begin
                    // Nothing issued while held
                    if ((stallBank2 ? resume2 : resume1) && resumeTnr) begin
                        abortOut <= stallBank2 ? ctl2[`CFH_CTL_FARE] :
                            ctl1[`CFH_CTL_FARE];
                        rspRdata <= 32'h0;
                        state <= ST_RESP;
                    // Retry rechecks the request's banks from scratch
                    end else if (stallBank2 ? (resume2 || !flt2) :
                        (resume1 || !flt1)) begin
                        state <= ST_CHECK;
                    end
                end
                ST_RESP: begin
                    rspValid <= 1'b1;
                    rspAbort <= abortOut;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // cfh_context_fault_handler
`default_nettype wire

// ==== dv/cfh_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfh_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic rspAbort,
    input wire logic [31:0] rspRdata,
    input wire logic xlatStart,
    input wire logic xlatDone,
    input wire logic xlatFault,
    input wire logic dsValid,
    input wire logic [31:0] dsAddr,
    input wire logic dsDone
);
default clocking @(posedge clk_sys); endclocking
default disable iff (reset);
ack_timing_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
err_zero_a: assert property (!wb_err_o) else $error("err raised");
abort_zero_a: assert property (
    rspValid && rspAbort |-> rspRdata == 32'h0)
    else $error("abort carries data");
rsp_pulse_a: assert property (
    rspValid |=> !rspValid && reqReady) else $error("response not single");
check_gap_a: assert property (
    reqValid && reqReady |=> !xlatStart && !rspValid && !reqReady)
    else $error("no check cycle");
ds_cause_a: assert property (
    $rose(dsValid) |-> $past(xlatDone) && !$past(xlatFault))
    else $error("downstream without clean xlat");
fault_no_ds_a: assert property (
    xlatDone && xlatFault |=> !dsValid [*2])
    else $error("downstream after fault");
ds_hold_a: assert property (
    dsValid && !dsDone |=> dsValid && $stable(dsAddr))
    else $error("downstream request dropped");
cover property (rspValid && rspAbort);
cover property (rspValid && !rspAbort);
cover property (xlatDone && xlatFault);
endmodule // cfh_chk
`default_nettype wire

// ==== dv/cfh_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfh_far_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic inject,
    input wire logic slow,
    input wire logic xlatStart,
    output logic xlatDone,
    output logic xlatFault,
    output logic xlatFaultS2,
    output logic [31:0] xlatSyndrome,
    input wire logic dsValid,
    input wire logic [31:0] dsAddr,
    output logic dsDone,
    output logic [31:0] dsRdata
);
logic [3:0] xc, dc;
logic [31:0] pat;
// Qualified outputs churn outside their pulse so stale values never match
assign xlatFault = xlatDone ? inject : pat[0];
assign xlatFaultS2 = xlatDone ? 1'b0 : pat[1];
assign xlatSyndrome = xlatDone ? 32'h5 : pat;
assign dsRdata = dsDone ? ~dsAddr : pat;
always_ff @(posedge clk_sys) begin
    xlatDone <= 1'b0;
    dsDone <= 1'b0;
    pat <= pat + 32'h9e37;
    if (reset) begin
        xc <= 4'h0;
        dc <= 4'h0;
        pat <= 32'h0;
    end else begin
        if (xlatStart) begin
            xc <= slow ? 4'h6 : 4'h1;
        end else if (xc != 4'h0) begin
            xc <= xc - 4'h1;
            xlatDone <= (xc == 4'h1);
        end
        if (dsValid && !dsDone) begin
            dc <= dc + 4'h1;
            if (dc == (slow ? 4'h4 : 4'h0)) begin
                dsDone <= 1'b1;
                dc <= 4'h0;
            end
        end
    end
end
endmodule // cfh_far_model
`default_nettype wire

// ==== dv/cfh_context_fault_handler_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfh_context_fault_handler_tb;
logic clk_sys, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
logic reqValid = 0, reqWrite = 0, reqUseS1 = 1, reqUseS2 = 0;
logic inject = 0, slow = 0, got, ab;
logic [3:0] wb_sel_i = 4'hf;
logic [5:0] wb_adr_i = 6'h0;
logic [31:0] wb_dat_i = 0, reqAddr = 0, reqWdata = 0, rd, rdv, a;
logic [31:0] seed = 32'h7977;
wire wb_ack_o, wb_err_o, reqReady, rspValid, rspAbort, xlatStart;
wire xlatDone, xlatFault, xlatFaultS2, dsValid, dsWrite, dsDone;
wire [31:0] wb_dat_o, rspRdata, xlatAddr, xlatSyndrome, dsAddr, dsWdata;
wire [31:0] dsRdata;
int fail_count = 0, n_compared = 0, i;
cfh_context_fault_handler DUT (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .reqValid, .reqReady, .reqWrite, .reqUseS1, .reqUseS2,
    .reqAddr, .reqWdata, .rspValid, .rspAbort, .rspRdata, .xlatStart,
    .xlatAddr, .xlatDone, .xlatFault, .xlatFaultS2, .xlatSyndrome,
    .dsValid, .dsWrite, .dsAddr, .dsWdata, .dsDone, .dsRdata);
cfh_far_model u_far (.clk_sys, .reset, .inject, .slow, .xlatStart,
    .xlatDone, .xlatFault, .xlatFaultS2, .xlatSyndrome, .dsValid, .dsAddr,
    .dsDone, .dsRdata);
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
        fail_count++;
        $display("[ERR] %s expected %h seen %h", n, e, g);
    end
endtask
task automatic wb(logic w, logic [3:0] ix, logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w;
    wb_adr_i <= {ix, 2'b00}; wb_dat_i <= d;
    // Waits for ack however long; only the watchdog ends a hang
    do @(posedge clk_sys); while (wb_ack_o !== 1);
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
endtask
task automatic rc(logic [3:0] ix, logic [31:0] e);
    wb(0, ix, 0);
    chk($sformatf("reg%0d", ix), e, rd);
endtask
task automatic wt(int lim);
    int k;
    k = 0; got = 0;
    while (!got && k < lim) begin
        @(posedge clk_sys); got = (rspValid === 1); k++;
    end
    ab = rspAbort; rdv = rspRdata;
endtask
task automatic rq(logic w, logic [31:0] ad, int lim);
    @(posedge clk_sys);
    reqValid <= 1; reqWrite <= w; reqAddr <= ad; reqWdata <= rnd();
    do @(posedge clk_sys); while (reqReady !== 1);
    reqValid <= 0;
    wt(lim);
endtask
task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
end
// Request fields stay put until the next request, so they serve as reference
always @(posedge clk_sys) begin
    if (xlatStart === 1) chk("xaddr", reqAddr, xlatAddr);
    if (dsValid === 1 && dsDone === 1) begin
        chk("dswrite", {31'h0, reqWrite}, {31'h0, dsWrite});
        chk("dswdata", reqWdata, dsWdata);
    end
end
// Whole run needs under a thousand cycles; this allows 50000 cycles
initial begin
    #200000;
    fail_count++;
    finish_test();
end
initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 0;
    rc(4'h1, 32'h0); rc(4'h3, 32'h0); rc(4'hf, 32'h0);
    for (i = 0; i < 6; i++) begin
        a = rnd(); slow <= a[4];
        rq(a[0], a, 200); chk("rsp", 1, got);
        chk("abort", 0, ab); chk("rdata", a[0] ? 0 : ~a, rdv);
    end
    inject <= 1; wb(1, 4'h1, 32'h4);
    rq(0, a, 200); chk("abort", 1, ab); chk("rdata", 0, rdv);
    rc(4'h3, 32'h1);
    rc(4'h7, a); rc(4'ha, 32'h5);
    rq(1, a, 200); chk("abort", 1, ab); rc(4'h3, 32'h1);
    wb(1, 4'h1, 32'h6);
    rq(0, a, 200); chk("abort", 1, ab); rc(4'h3, 32'h5);
    wb(1, 4'h3, 32'h7); rc(4'h3, 32'h0);
    wb(1, 4'h1, 32'h0);
    rq(0, a, 200); chk("rsp", 1, got); chk("abort", 0, ab);
    wb(1, 4'h3, 32'h7);
    // Stall mode with abort reporting enabled
    wb(1, 4'h1, 32'h5);
    rq(0, a, 40); chk("stalled", 0, got); rc(4'h3, 32'h3);
    wb(1, 4'h5, 32'h1); wt(200); chk("abort", 1, ab);
    chk("rsp", 1, got); chk("rdata", 0, rdv);
    rc(4'h3, 32'h1);
    wb(1, 4'h3, 32'h7);
    rq(0, a, 40); inject <= 0; wb(1, 4'h3, 32'h1);
    wb(1, 4'h5, 32'h0); wt(200); chk("retry", 1, got);
    chk("rdata", ~a, rdv); rc(4'h3, 32'h0);
    inject <= 1; rq(0, a, 40); inject <= 0; wb(1, 4'h3, 32'h1);
    wb(1, 4'h7, 32'h0); wt(200); chk("attr retry", 1, got);
    chk("rdata", ~a, rdv); rc(4'h3, 32'h0);
    for (i = 0; i < 2; i++) begin
        wb(1, 4'h0, 32'h1 << i); rc(4'h1, 32'h4);
    end
    wb(1, 4'h0, 32'h0); wb_sel_i <= 4'h0; wb(1, 4'h1, 32'h0);
    wb_sel_i <= 4'hf; rc(4'h1, 32'h5);
    finish_test();
end
endmodule // cfh_context_fault_handler_tb
bind cfh_context_fault_handler cfh_chk u_chk (.clk_sys, .reset, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_err_o, .reqValid, .reqReady, .rspValid,
    .rspAbort, .rspRdata, .xlatStart, .xlatDone, .xlatFault, .dsValid,
    .dsAddr, .dsDone);
`default_nettype wire
